// ==== shared/sss_pkg.sv ====
/*
  Shared constants and types for the streaming session scheduler:
  command codes, slot codes, timing defaults, carriers and state types.
  Assumes a single 25 MHz system clock and a separate reply engine that
  produces the bytes of each streamed command.
*/
// Notes on behaviour
// R01: Besides request and reply, a session replays configured commands without host requests.
// R02: Eight slots, each one command code, all loaded together by command 0x50.
// R03: Unused slots hold 0xff; such a slot emits nothing in a cycle.
// R04: Set-slots is refused when the eight reply lengths sum above 256 bytes.
// R05: Codes 0x00 through 0x0c are streamable.
// R06: Codes 0x20-0x23 and 0x25-0x29 are streamable; 0x24 is not.
// R07: Codes 0x2b-0x2d and 0x40-0x43 are streamable; 0x2a is not.
// R08: Codes 0xc9-0xcb, 0xfa and 0xff are streamable; all others refused.
// R09: Command 0x52 sets interval, duration and start delay, in microseconds.
// R10: One slot pass per interval; interval zero repeats passes back to back.
// R11: An interval written as 1 to 1000 is stored as 1000.
// R12: Session ends when duration elapses; 4294967295 means run until stopped.
// R13: After start, wait the start delay before the first pass.
// R14: Command 0x55 starts a session, 0x56 stops it.
// R15: Streamed replies are always binary, even after a text-format start.
// R16: An output buffer overflow during streaming ends the session.
// R17: Streamed data goes out on the interface the start arrived on.
// R18: Start from the SPI interface is refused.
// R19: Reset defaults: interval 10000, duration 4294967295, delay 0, slots 255.
// R20: Timing counters run on a microsecond tick and restart at each start.
package sss_pkg;

  // ----------------------------------------------------------------
  // Sizes and clock
  // ----------------------------------------------------------------
  localparam int SLOT_COUNT = 8;
  localparam int CNT_W = 32;
  localparam int CLK_HZ = 25_000_000;
  localparam int TICK_US = 1;
  localparam int TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int MAX_REPLY_BYTES = 256;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_SET_SLOTS = 8'h50;
  localparam logic [7:0] OP_SET_TIMING = 8'h52;
  localparam logic [7:0] OP_START = 8'h55;
  localparam logic [7:0] OP_STOP = 8'h56;
  localparam logic [7:0] NO_CMD = 8'hff;

  // ----------------------------------------------------------------
  // Streamable code ranges
  // ----------------------------------------------------------------
  localparam logic [7:0] ORIENT_LO = 8'h00;
  localparam logic [7:0] ORIENT_HI = 8'h0c;
  localparam logic [7:0] NORM_LO = 8'h20;
  localparam logic [7:0] NORM_HI = 8'h23;
  localparam logic [7:0] CORR_LO = 8'h25;
  localparam logic [7:0] CORR_HI = 8'h29;
  localparam logic [7:0] TEMP_LO = 8'h2b;
  localparam logic [7:0] TEMP_HI = 8'h2d;
  localparam logic [7:0] RAW_LO = 8'h40;
  localparam logic [7:0] RAW_HI = 8'h43;
  localparam logic [7:0] BATT_LO = 8'hc9;
  localparam logic [7:0] BATT_HI = 8'hcb;
  localparam logic [7:0] BUTTON_CODE = 8'hfa;

  // ----------------------------------------------------------------
  // Timing values and reset defaults
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] INTERVAL_MIN = 32'h0000_03e8;
  localparam logic [CNT_W-1:0] DEF_INTERVAL = 32'h0000_2710;
  localparam logic [CNT_W-1:0] DEF_DURATION = 32'hffff_ffff;
  localparam logic [CNT_W-1:0] DEF_DELAY = 32'h0000_0000;
  localparam logic [CNT_W-1:0] DURATION_FOREVER = 32'hffff_ffff;
  localparam logic [7:0] DEF_SLOT = 8'hff;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    IF_USB = 2'h0,
    IF_SERIAL = 2'h1,
    IF_SPI = 2'h2
  } sss_iface_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DELAY = 2'b01,
    ST_EMIT = 2'b11,
    ST_WAIT = 2'b10
  } sss_state_t;

  typedef enum logic [1:0] {
    END_NONE = 2'h0,
    END_STOP = 2'h1,
    END_EXPIRED = 2'h2,
    END_OVERFLOW = 2'h3
  } sss_end_t;

  typedef struct packed {
    logic [7:0] code;
    sss_iface_t iface;
    logic text;
  } sss_cmd_t;

  typedef struct packed {
    logic [CNT_W-1:0] interval;
    logic [CNT_W-1:0] duration;
    logic [CNT_W-1:0] delay;
  } sss_timing_t;

  typedef logic [SLOT_COUNT-1:0][7:0] sss_slots_t;

endpackage

// ==== rtl/sss_tick.sv ====
/*
  Microsecond tick generator for the session timers.
  Assumes the clock rate given in the package and a clock enable that
  freezes the divider together with the rest of the block.
*/
`timescale 1ns/1ps
module sss_tick
  import sss_pkg::*;
#(
  parameter int DIV = TICK_CYCLES
) (
  // Clock and control
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic restart,
  // Tick out
  output logic tick
);

  logic [7:0] div_cnt;

  // Restart aligns the first tick one full microsecond after a start
  always_ff @(posedge ref_clk) begin // see R20
    if (reset) begin
      div_cnt <= 8'h00;
      tick <= 1'b0;
    end else if (ce) begin
      if (restart || div_cnt == 8'(DIV - 1)) begin
        div_cnt <= 8'h00;
      end else begin
        div_cnt <= div_cnt + 8'h01;
      end
      tick <= !restart && div_cnt == 8'(DIV - 1);
    end
  end

endmodule

// ==== rtl/sss_slot_check.sv ====
/*
  Slot code check: tells whether a code may sit in a streaming slot and
  how many reply bytes it adds to one pass.
  Assumes reply lengths per command group are set by parameters to match
  the reply engine.
*/
`timescale 1ns/1ps
module sss_slot_check
  import sss_pkg::*;
#(
  parameter int LEN_ORIENT = 16,
  parameter int LEN_SENSOR = 36,
  parameter int LEN_TEMP = 4,
  parameter int LEN_RAW = 36,
  parameter int LEN_BATT = 1,
  parameter int LEN_BUTTON = 1
) (
  // Slot code in
  input wire logic [7:0] code,
  // Verdict out
  output logic ok,
  output logic [8:0] len
);

  always_comb begin
    ok = 1'b1;
    len = 9'h000;
    if (code >= ORIENT_LO && code <= ORIENT_HI) begin // see R05
      len = 9'(LEN_ORIENT);
    end else if ((code >= NORM_LO && code <= NORM_HI) ||
                 (code >= CORR_LO && code <= CORR_HI)) begin // see R06
      len = 9'(LEN_SENSOR);
    end else if (code >= TEMP_LO && code <= TEMP_HI) begin // see R07
      len = 9'(LEN_TEMP);
    end else if (code >= RAW_LO && code <= RAW_HI) begin // see R07
      len = 9'(LEN_RAW);
    end else if (code >= BATT_LO && code <= BATT_HI) begin // see R08
      len = 9'(LEN_BATT);
    end else if (code == BUTTON_CODE) begin // see R08
      len = 9'(LEN_BUTTON);
    end else if (code == NO_CMD) begin // see R03
      len = 9'h000;
    end else begin // see R08
      ok = 1'b0;
    end
  end

endmodule

// ==== rtl/sss_scheduler.sv ====
/*
  Streaming session scheduler. Holds the eight slots and the timing set,
  answers the four streaming commands, and during a session hands the
  slot codes one by one to the reply engine on a valid/ready handshake.
  Assumes the command decoder presents one command per cmd_valid pulse
  with its parameters already assembled, and that the reply engine
  raises buf_overflow when its output buffer overruns.
*/
`timescale 1ns/1ps
module sss_scheduler
  import sss_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic ce,
  // Command in
  input wire logic cmd_valid,
  input wire sss_cmd_t cmd,
  input wire sss_slots_t cmd_slots,
  input wire sss_timing_t cmd_timing,
  // Command answer
  output logic cmd_done,
  output logic cmd_ok,
  // Slot issue to reply engine
  output logic out_valid,
  input wire logic out_ready,
  output logic [7:0] out_code,
  output sss_iface_t out_iface,
  output logic out_binary,
  // Reply engine status
  input wire logic buf_overflow,
  // Session status
  output logic streaming,
  output logic session_end,
  output sss_end_t end_reason,
  output sss_timing_t timing
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  sss_slots_t slots;
  sss_state_t state;
  sss_state_t next_state;
  sss_iface_t sess_iface;
  logic [SLOT_COUNT-1:0] slot_ok;
  logic [SLOT_COUNT-1:0][8:0] slot_len;
  logic [11:0] total_len;
  logic set_ok;
  logic [2:0] slot_idx;
  logic [CNT_W-1:0] delay_cnt;
  logic [CNT_W-1:0] ivl_cnt;
  logic [CNT_W-1:0] dur_cnt;
  logic tick;
  logic idle;
  logic active;
  logic is_set_slots;
  logic is_set_timing;
  logic is_start;
  logic is_stop;
  logic take_slots;
  logic take_timing;
  logic start_ok;
  logic dur_hit;
  logic end_now;
  logic cycle_start;
  logic last_slot;
  logic slot_empty;
  logic slot_step;
  logic [CNT_W-1:0] next_interval;

  // ----------------------------------------------------------------
  // Slot checks and reply length sum
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < SLOT_COUNT; gi++) begin : g_slot
      sss_slot_check u_check (
        .code (cmd_slots[gi]),
        .ok   (slot_ok[gi]),
        .len  (slot_len[gi])
      );
    end
  endgenerate

  always_comb begin
    total_len = 12'h000;
    for (int i = 0; i < SLOT_COUNT; i++) begin
      total_len = total_len + {3'b000, slot_len[i]};
    end
  end

  // Refuse the whole set if any code is unknown or the pass is too long
  assign set_ok = (&slot_ok) && (total_len <= 12'(MAX_REPLY_BYTES)); // see R04

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  assign idle = (state == ST_IDLE);
  assign active = !idle;
  assign is_set_slots = cmd_valid && cmd.code == OP_SET_SLOTS;
  assign is_set_timing = cmd_valid && cmd.code == OP_SET_TIMING;
  assign is_start = cmd_valid && cmd.code == OP_START;
  assign is_stop = cmd_valid && cmd.code == OP_STOP;

  // Configuration is frozen while a session runs, so a pass never mixes sets
  assign take_slots = is_set_slots && idle && set_ok; // see R02
  assign take_timing = is_set_timing && idle; // see R09
  assign start_ok = is_start && idle && cmd.iface != IF_SPI; // see R14, see R18

  always_comb begin // see R11
    next_interval = cmd_timing.interval;
    if (cmd_timing.interval != '0 && cmd_timing.interval < INTERVAL_MIN) begin
      next_interval = INTERVAL_MIN;
    end
  end

  // ----------------------------------------------------------------
  // Configuration store
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin // see R19
      for (int i = 0; i < SLOT_COUNT; i++) begin
        slots[i] <= DEF_SLOT;
      end
    end else if (ce && take_slots) begin // see R02
      slots <= cmd_slots;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin // see R19
      timing.interval <= DEF_INTERVAL;
      timing.duration <= DEF_DURATION;
      timing.delay <= DEF_DELAY;
    end else if (ce && take_timing) begin // see R09
      timing.interval <= next_interval; // see R11
      timing.duration <= cmd_timing.duration;
      timing.delay <= cmd_timing.delay;
    end
  end

  // ----------------------------------------------------------------
  // Command answer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cmd_done <= 1'b0;
      cmd_ok <= 1'b0;
    end else if (ce) begin
      cmd_done <= is_set_slots || is_set_timing || is_start || is_stop;
      cmd_ok <= take_slots || take_timing || start_ok || is_stop;
    end
  end

  // ----------------------------------------------------------------
  // Microsecond time base
  // ----------------------------------------------------------------
  sss_tick #(
    .DIV (TICK_DIV)
  ) u_tick (
    .ref_clk (ref_clk),
    .reset   (reset),
    .ce      (ce),
    .restart (start_ok),
    .tick    (tick)
  );

  // ----------------------------------------------------------------
  // Session timers
  // ----------------------------------------------------------------
  // Counters saturate so a long idle wait cannot wrap into a false hit
  always_ff @(posedge ref_clk) begin // see R13, see R20
    if (reset) begin
      delay_cnt <= '0;
    end else if (ce) begin
      if (start_ok) begin
        delay_cnt <= '0;
      end else if (state == ST_DELAY && tick && delay_cnt != '1) begin
        delay_cnt <= delay_cnt + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge ref_clk) begin // see R10, see R20
    if (reset) begin
      ivl_cnt <= '0;
    end else if (ce) begin
      if (start_ok || cycle_start) begin
        ivl_cnt <= '0;
      end else if (active && tick && ivl_cnt != '1) begin
        ivl_cnt <= ivl_cnt + 32'h0000_0001;
      end
    end
  end

  // Duration runs from the end of the start delay
  always_ff @(posedge ref_clk) begin // see R12, see R20
    if (reset) begin
      dur_cnt <= '0;
    end else if (ce) begin
      if (start_ok) begin
        dur_cnt <= '0;
      end else if ((state == ST_EMIT || state == ST_WAIT) && tick && dur_cnt != '1) begin
        dur_cnt <= dur_cnt + 32'h0000_0001;
      end
    end
  end

  assign dur_hit = (state == ST_EMIT || state == ST_WAIT) &&
                   timing.duration != DURATION_FOREVER &&
                   dur_cnt >= timing.duration; // see R12
  assign end_now = active && (is_stop || buf_overflow || dur_hit); // see R14, see R16

  // A pass that overruns the interval is followed by the next at once
  assign cycle_start = (state == ST_DELAY && delay_cnt >= timing.delay) ||
                       (state == ST_WAIT && ivl_cnt >= timing.interval); // see R10, see R13

  // ----------------------------------------------------------------
  // Slot walk
  // ----------------------------------------------------------------
  assign last_slot = (slot_idx == 3'(SLOT_COUNT - 1));
  assign slot_empty = (slots[slot_idx] == NO_CMD);
  assign slot_step = (state == ST_EMIT) &&
                     ((!out_valid && slot_empty) || (out_valid && out_ready)); // see R03

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start_ok) begin
          next_state = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (cycle_start) begin
          next_state = ST_EMIT;
        end
      end
      ST_EMIT: begin
        if (slot_step && last_slot) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (cycle_start) begin
          next_state = ST_EMIT;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (end_now) begin
      next_state = ST_IDLE;
    end
  end

  always_ff @(posedge ref_clk) begin // see R01
    if (reset) begin
      state <= ST_IDLE;
    end else if (ce) begin
      state <= next_state;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      slot_idx <= 3'h0;
    end else if (ce) begin
      if (start_ok || cycle_start) begin
        slot_idx <= 3'h0;
      end else if (slot_step) begin
        slot_idx <= slot_idx + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Slot issue
  // ----------------------------------------------------------------
  // An end mid-pass withdraws the pending slot; the reply engine sees no
  // half-issued request after the session stops
  always_ff @(posedge ref_clk) begin // see R01, see R03
    if (reset) begin
      out_valid <= 1'b0;
      out_code <= NO_CMD;
    end else if (ce) begin
      if (end_now) begin
        out_valid <= 1'b0;
      end else if (state == ST_EMIT && !out_valid && !slot_empty) begin
        out_valid <= 1'b1;
        out_code <= slots[slot_idx];
      end else if (out_valid && out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin // see R17
    if (reset) begin
      sess_iface <= IF_USB;
    end else if (ce && start_ok) begin
      sess_iface <= cmd.iface;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      out_iface <= IF_USB;
      out_binary <= 1'b1;
    end else if (ce) begin
      out_iface <= start_ok ? cmd.iface : sess_iface; // see R17
      out_binary <= 1'b1; // see R15
    end
  end

  // ----------------------------------------------------------------
  // Session status
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      streaming <= 1'b0;
      session_end <= 1'b0;
      end_reason <= END_NONE;
    end else if (ce) begin
      streaming <= (next_state != ST_IDLE);
      session_end <= end_now;
      if (start_ok) begin
        end_reason <= END_NONE;
      end else if (end_now) begin
        if (buf_overflow) begin // see R16
          end_reason <= END_OVERFLOW;
        end else if (is_stop) begin // see R14
          end_reason <= END_STOP;
        end else begin // see R12
          end_reason <= END_EXPIRED;
        end
      end
    end
  end

endmodule

// ==== verif/sss_monitor.sv ====
/*
  Port checker for the session scheduler.
  Assumes it is bound onto sss_scheduler; ce may drop to freeze the block.
*/
`timescale 1ns/1ps
module sss_monitor
  import sss_pkg::*;
(
  // Clock and inputs
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic cmd_valid,
  input wire sss_cmd_t cmd,
  input wire sss_timing_t cmd_timing,
  input wire logic out_ready,
  input wire logic buf_overflow,
  // Outputs watched
  input wire logic cmd_done,
  input wire logic cmd_ok,
  input wire logic out_valid,
  input wire logic [7:0] out_code,
  input wire logic out_binary,
  input wire logic streaming,
  input wire logic session_end,
  input wire sss_end_t end_reason,
  input wire sss_timing_t timing
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence cmd_in(logic [7:0] op);
    ce && cmd_valid && cmd.code == op;
  endsequence

  set_answer_a: assert property (cmd_in(OP_SET_SLOTS) |=> cmd_done)
    else $error("set-slots not answered");
  stop_answer_a: assert property (cmd_in(OP_STOP) |=> cmd_done && cmd_ok)
    else $error("stop not accepted");
  spi_refuse_a: assert property (cmd_in(OP_START) ##0 cmd.iface == IF_SPI |=> !cmd_ok)
    else $error("start over spi accepted");
  interval_clamp_a: assert property (cmd_in(OP_SET_TIMING) ##0 (!streaming &&
    cmd_timing.interval inside {[1:1000]}) |=> timing.interval == INTERVAL_MIN)
    else $error("short interval not clamped");
  slot_hold_a: assert property (out_valid && !out_ready |=>
    (out_valid && $stable(out_code)) || !streaming)
    else $error("slot request dropped early");
  no_empty_a: assert property (out_valid |-> out_code != NO_CMD)
    else $error("empty slot issued");
  binary_out_a: assert property (out_binary)
    else $error("reply not binary");
  overflow_end_a: assert property (ce && streaming && buf_overflow |=> ##[0:1]
    (session_end && end_reason == END_OVERFLOW))
    else $error("overflow did not end session");
  issue_live_a: assert property (out_valid |-> streaming)
    else $error("slot issued while idle");
endmodule

// ==== verif/sss_reply_model.sv ====
/*
  Reply engine model: takes slot requests, either at once or with stalls.
  Assumes the bench asks for overflow through ovf_req.
*/
`timescale 1ns/1ps
module sss_reply_model (
  // Clock and control
  input wire logic ref_clk,
  input wire logic slow,
  input wire logic ovf_req,
  // Scheduler side
  input wire logic out_valid,
  output logic out_ready,
  output logic buf_overflow
);
  logic [1:0] stall = 2'h0;
  logic ready_q = 1'b1;

  // Slow mode keeps a pending request waiting four cycles to stress the hold rule
  always @(negedge ref_clk) begin
    if (out_valid) begin
      stall <= stall + 2'h1;
    end
    ready_q <= !slow || (stall == 2'h3);
  end
  assign out_ready = ready_q;
  assign buf_overflow = ovf_req;
endmodule

// ==== verif/sss_scheduler_tb.sv ====
/*
  Testbench for the session scheduler: command tasks and streaming checks.
  Assumes TICK_DIV of 2 so that microsecond counts stay short.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module sss_scheduler_tb
  import sss_pkg::*;
;
  logic ref_clk = 0, reset = 1, ce = 1, cmd_valid = 0, slow = 0, ovf = 0;
  sss_cmd_t cmd = '0;
  sss_slots_t cmd_slots = '0;
  sss_timing_t cmd_timing = '0;
  logic cmd_done, cmd_ok, out_valid, out_ready, out_binary, streaming, session_end, buf_overflow;
  logic [7:0] out_code;
  sss_iface_t out_iface;
  sss_end_t end_reason;
  sss_timing_t timing;
  int fail_count = 0, cmp_count = 0, cyc = 0, first_hs = 0, start_cyc = 0;
  logic [7:0] got[$];
  logic [7:0] pat[3] = '{ORIENT_LO, TEMP_LO, BUTTON_CODE};

  always #20 ref_clk = ~ref_clk;

  sss_scheduler #(.TICK_DIV(2)) i_sss_scheduler (.ref_clk(ref_clk), .reset(reset), .ce(ce),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_slots(cmd_slots), .cmd_timing(cmd_timing),
    .cmd_done(cmd_done), .cmd_ok(cmd_ok), .out_valid(out_valid), .out_ready(out_ready),
    .out_code(out_code), .out_iface(out_iface), .out_binary(out_binary),
    .buf_overflow(buf_overflow), .streaming(streaming), .session_end(session_end),
    .end_reason(end_reason), .timing(timing));
  sss_reply_model i_sss_reply_model (.ref_clk(ref_clk), .slow(slow), .ovf_req(ovf),
    .out_valid(out_valid), .out_ready(out_ready), .buf_overflow(buf_overflow));

  always @(posedge ref_clk) begin
    cyc++;
    if (!reset && out_valid && out_ready) begin
      if (got.size() == 0) first_hs = cyc;
      got.push_back(out_code);
    end
  end

  function automatic logic good_code(logic [7:0] c);
    return c <= ORIENT_HI || (c >= NORM_LO && c <= CORR_HI && c != 8'h24) ||
      (c >= TEMP_LO && c <= TEMP_HI) || (c >= RAW_LO && c <= RAW_HI) ||
      (c >= BATT_LO && c <= BATT_HI) || c == BUTTON_CODE || c == NO_CMD;
  endfunction

  // Text flag set on purpose: replies must stay binary anyway
  task automatic cmd_chk(input logic [7:0] code, input sss_iface_t ifc, input logic exp);
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd = '{code: code, iface: ifc, text: 1'b1};
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    `CHK(cmd_done, 1'b1)
    `CHK(cmd_ok, exp)
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge ref_clk);
    fail_count++;
    final_report();
  end

  initial begin
    repeat (20) @(negedge ref_clk);
    reset = 1'b0;
    `CHK(timing, {DEF_INTERVAL, DEF_DURATION, DEF_DELAY})
    `CHK(out_binary, 1'b1)
    `CHK(streaming, 1'b0)
    cmd_chk(OP_START, IF_USB, 1'b1);
    repeat (40) @(negedge ref_clk);
    cmd_chk(OP_STOP, IF_USB, 1'b1);
    `CHK(got.size(), 0)
    $display("test defaults done");
    for (int c = 0; c < 256; c++) begin
      cmd_slots = {8{NO_CMD}};
      cmd_slots[3] = c[7:0];
      cmd_chk(OP_SET_SLOTS, IF_USB, good_code(c[7:0]));
    end
    cmd_slots = {8{RAW_LO}};
    cmd_chk(OP_SET_SLOTS, IF_USB, 1'b0);
    cmd_slots = {TEMP_LO, {7{NORM_LO}}};
    cmd_chk(OP_SET_SLOTS, IF_USB, 1'b1);
    $display("test slot codes done");
    cmd_timing = '{interval: 0, duration: 2500, delay: 10};
    cmd_chk(OP_SET_TIMING, IF_USB, 1'b1);
    `CHK(timing.interval, 32'h0000_0000)
    cmd_timing.interval = 5;
    cmd_chk(OP_SET_TIMING, IF_USB, 1'b1);
    `CHK(timing, {INTERVAL_MIN, 32'h0000_09c4, 32'h0000_000a})
    $display("test timing done");
    cmd_slots = {BUTTON_CODE, {4{NO_CMD}}, TEMP_LO, NO_CMD, ORIENT_LO};
    cmd_chk(OP_SET_SLOTS, IF_USB, 1'b1);
    got.delete();
    start_cyc = cyc;
    cmd_chk(OP_START, IF_USB, 1'b1);
    `CHK(streaming, 1'b1)
    for (int i = 0; i < 8000 && !session_end; i++) @(negedge ref_clk);
    `CHK(end_reason, END_EXPIRED)
    `CHK(got.size(), 9)
    foreach (got[i]) `CHK(got[i], pat[i % 3])
    `CHK(first_hs - start_cyc >= 20, 1'b1)
    $display("test timed session done");
    for (int i = 0; i < 8; i++) cmd_slots[i] = 8'(i + 1);
    cmd_timing = '{interval: 0, duration: DURATION_FOREVER, delay: 0};
    cmd_chk(OP_SET_SLOTS, IF_USB, 1'b1);
    cmd_chk(OP_SET_TIMING, IF_USB, 1'b1);
    cmd_chk(OP_START, IF_SPI, 1'b0);
    got.delete();
    slow = 1'b1;
    cmd_chk(OP_START, IF_SERIAL, 1'b1);
    `CHK(out_iface, IF_SERIAL)
    repeat (200) @(negedge ref_clk);
    cmd_chk(OP_SET_SLOTS, IF_USB, 1'b0);
    cmd_chk(OP_SET_TIMING, IF_USB, 1'b0);
    cmd_chk(OP_START, IF_USB, 1'b0);
    `CHK(streaming, 1'b1)
    cmd_chk(OP_STOP, IF_SERIAL, 1'b1);
    repeat (2) @(negedge ref_clk);
    `CHK(streaming, 1'b0)
    `CHK(end_reason, END_STOP)
    `CHK(got.size() > 16, 1'b1)
    foreach (got[i]) `CHK(got[i], 8'(i % 8 + 1))
    $display("test stop session done");
    slow = 1'b0;
    cmd_chk(OP_START, IF_USB, 1'b1);
    `CHK(out_iface, IF_USB)
    // A frozen block must not act on an overflow it cannot clock in
    ce = 1'b0;
    ovf = 1'b1;
    repeat (3) @(negedge ref_clk);
    `CHK(streaming, 1'b1)
    ovf = 1'b0;
    ce = 1'b1;
    repeat (30) @(negedge ref_clk);
    ovf = 1'b1;
    @(negedge ref_clk);
    ovf = 1'b0;
    repeat (2) @(negedge ref_clk);
    `CHK(streaming, 1'b0)
    `CHK(end_reason, END_OVERFLOW)
    $display("test overflow done");
    final_report();
  end
endmodule

bind sss_scheduler sss_monitor i_sss_monitor (.ref_clk(ref_clk), .reset(reset), .ce(ce),
  .cmd_valid(cmd_valid), .cmd(cmd), .cmd_timing(cmd_timing), .out_ready(out_ready),
  .buf_overflow(buf_overflow), .cmd_done(cmd_done), .cmd_ok(cmd_ok), .out_valid(out_valid),
  .out_code(out_code), .out_binary(out_binary), .streaming(streaming),
  .session_end(session_end), .end_reason(end_reason), .timing(timing));
